// *** design/iwrc_top.sv ***
// interrupt flags, wake-up, vectoring and return control
`timescale 1ns/1ps
`include "iwrc_cfg.svh"
module iwrc_top
    import iwrc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // peripheral events and external pins
    input wire logic [7:0] src_event,
    input wire logic [1:0] ext_pin,
    // software control
    input wire logic [7:0] sw_flag_set,
    input wire logic [7:0] sw_flag_clr,
    input wire logic [7:0] src_enable,
    input wire logic shared_vector_enable,
    input wire logic sw_svf_set,
    input wire logic sw_svf_clr,
    input wire logic sw_gie_set,
    input wire logic sw_gie_clr,
    // core side
    input wire iwrc_core_s core_i,
    output iwrc_vec_s vec_o,
    // status
    output logic [7:0] req_flag,
    output logic shared_vector_flag,
    output logic global_irq_enable,
    output iwrc_pwr_e pwr_state,
    output logic osc_run,
    output logic cpu_run,
    output logic periph_clk_run,
    output logic wake_pulse,
    output logic resume_pulse
);
    localparam int WakeBnd = `IWRC_WAKE_CYC;

    // ----------------------------------------------------------------
    // request flags
    // ----------------------------------------------------------------
    logic [`IWRC_NFLAG-1:0] flag_set;
    logic [`IWRC_NFLAG-1:0] flag_clr;
    logic [`IWRC_NFLAG-1:0] flag_q;
    logic [`IWRC_NFLAG-1:0] flag_rose;
    logic [1:0] ext_pin_q;
    logic [1:0] ext_edge;
    logic [3:0] member_req;
    logic [3:0] member_req_q;
    logic svf_set;
    logic take;
    logic [2:0] take_idx;
    logic [3:0] auto_clr;

    // pin edges are seen in every power state, the block sits on the always-on clock
    assign ext_edge = ext_pin & ~ext_pin_q;
    // shared flag rises when any enabled member becomes pending
    assign member_req = req_flag[7:4] & src_enable[7:4];
    assign svf_set = (|(member_req & ~member_req_q)) | sw_svf_set;
    // dedicated vectors clear their own flag when taken
    assign auto_clr = take ? (4'h1 << take_idx[1:0]) & {4{~take_idx[2]}} : 4'h0;

    // set and clear terms per flag
    assign flag_set[1:0] = src_event[1:0] | sw_flag_set[1:0];
    assign flag_set[`IWRC_EXT0_BIT] = src_event[2] | sw_flag_set[2] | ext_edge[0];
    assign flag_set[`IWRC_EXT1_BIT] = src_event[3] | sw_flag_set[3] | ext_edge[1];
    assign flag_set[7:4] = src_event[7:4] | sw_flag_set[7:4];
    assign flag_set[`IWRC_SVF_BIT] = svf_set;
    // members are cleared by software only, never by service
    assign flag_clr[3:0] = sw_flag_clr[3:0] | auto_clr;
    assign flag_clr[7:4] = sw_flag_clr[7:4];
    assign flag_clr[`IWRC_SVF_BIT] = sw_svf_clr | (take && take_idx == `IWRC_SHARED_VEC);

    genvar gi;
    generate
        for (gi = 0; gi < `IWRC_NFLAG; gi++) begin : g_flag
            iwrc_flag_cell u_cell (
                .ref_clk(ref_clk),
                .srst(srst),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .q(flag_q[gi]),
                .rose(flag_rose[gi])
            );
        end
    endgenerate

    assign req_flag = flag_q[7:0];
    assign shared_vector_flag = flag_q[`IWRC_SVF_BIT];

    // edge history for pins and members
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ext_pin_q <= 2'h0;
            member_req_q <= 4'h0;
        end else begin
            ext_pin_q <= ext_pin;
            member_req_q <= member_req;
        end
    end

    // ----------------------------------------------------------------
    // vector selection
    // ----------------------------------------------------------------
    logic [`IWRC_NVEC-1:0] vec_pend;
    logic exiting;

    // lowest vector number wins
    function automatic logic [2:0] first_set(input logic [4:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 4; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // dedicated and shared vector enables gate servicing only, flags stay pending when disabled
    assign vec_pend[3:0] = req_flag[3:0] & src_enable[3:0];
    assign vec_pend[4] = shared_vector_flag & shared_vector_enable;
    assign exiting = core_i.isr_exit_instr | core_i.plain_exit_instr;
    assign take_idx = first_set(vec_pend);
    // no vector while an exit retires, keeps the enable handover clean
    assign take = global_irq_enable && (|vec_pend) && !core_i.stack_full
        && core_i.boundary && !exiting && pwr_state == PWR_RUN;

    // ----------------------------------------------------------------
    // global enable
    // ----------------------------------------------------------------
    logic gie_set;
    logic gie_clr;

    // plain exit has no term here, so the enable stays where it was
    assign gie_set = sw_gie_set | core_i.isr_exit_instr;
    assign gie_clr = sw_gie_clr | take;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            global_irq_enable <= `IWRC_GIE_RST;
        end else begin
            global_irq_enable <= gie_set | (global_irq_enable & ~gie_clr);
        end
    end

    // ----------------------------------------------------------------
    // vector and stack commands
    // ----------------------------------------------------------------
    // only the program counter is handed to the stack
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vec_o <= '0;
        end else begin
            vec_o.take <= take;
            vec_o.push <= take;
            vec_o.addr <= `IWRC_VEC_BASE + (12'(take_idx) << `IWRC_VEC_SHIFT);
            vec_o.push_pc <= take ? core_i.pc : vec_o.push_pc;
            vec_o.pop <= exiting;
        end
    end

    // ----------------------------------------------------------------
    // power state and wake-up
    // ----------------------------------------------------------------
    iwrc_pwr_e pwr_d;
    logic [4:0] wake_cnt_q;
    logic [4:0] wake_cnt_d;
    logic any_rose;
    logic lowpower;
    logic wake_done;

    // any rising flag counts, enables are not looked at
    assign any_rose = |flag_rose;
    assign lowpower = pwr_state == PWR_SLEEP || pwr_state == PWR_IDLE;
    assign wake_done = pwr_state == PWR_WAKE && wake_cnt_q == 5'h0;

    // a flag rising in the halt cycle cancels the halt, else the wake is lost
    always_comb begin
        pwr_d = pwr_state;
        wake_cnt_d = wake_cnt_q;
        case (pwr_state)
            PWR_RUN: begin
                if (core_i.halt && !any_rose) begin
                    pwr_d = core_i.halt_idle ? PWR_IDLE : PWR_SLEEP;
                end
            end
            PWR_SLEEP, PWR_IDLE: begin
                if (any_rose) begin
                    pwr_d = PWR_WAKE;
                    wake_cnt_d = 5'(WakeBnd - 1);
                end
            end
            PWR_WAKE: begin
                // oscillator restart time before the core runs again
                if (wake_cnt_q == 5'h0) begin
                    pwr_d = PWR_RUN;
                end else begin
                    wake_cnt_d = wake_cnt_q - 5'h1;
                end
            end
            default: begin
                pwr_d = PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pwr_state <= PWR_RUN;
            wake_cnt_q <= 5'h0;
            wake_pulse <= 1'b0;
            resume_pulse <= 1'b0;
        end else begin
            pwr_state <= pwr_d;
            wake_cnt_q <= wake_cnt_d;
            wake_pulse <= lowpower && any_rose;
            resume_pulse <= wake_done;
        end
    end

    // clock controls follow the state; idle keeps peripheral clocks
    assign osc_run = pwr_state == PWR_RUN || pwr_state == PWR_WAKE;
    assign cpu_run = pwr_state == PWR_RUN;
    assign periph_clk_run = pwr_state != PWR_SLEEP;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_enter_wake;
        lowpower && any_rose;
    endsequence

    sequence s_restart;
        (pwr_state == PWR_WAKE) ##[1:WakeBnd] (resume_pulse && pwr_state == PWR_RUN);
    endsequence

    wake_on_rise_a: assert property (@(posedge ref_clk) disable iff (srst)
        s_enter_wake |=> (pwr_state == PWR_WAKE) && wake_pulse)
        else $error("flag rise did not wake");

    wake_ignores_enables_a: assert property (@(posedge ref_clk) disable iff (srst)
        lowpower && any_rose && !global_irq_enable && src_enable == 8'h0
        |=> pwr_state == PWR_WAKE)
        else $error("wake gated by enables");

    pin_edge_flag_a: assert property (@(posedge ref_clk) disable iff (srst)
        lowpower && ext_pin[0] && !ext_pin_q[0] && !req_flag[2]
        |=> req_flag[2] && pwr_state == PWR_WAKE)
        else $error("pin edge missed in low power");

    flag_holds_a: assert property (@(posedge ref_clk) disable iff (srst)
        req_flag[4] && !sw_flag_clr[4] |=> req_flag[4])
        else $error("pending flag lost");

    shared_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        take && take_idx == `IWRC_SHARED_VEC && !svf_set && sw_flag_clr[7:4] == 4'h0
        |=> !shared_vector_flag && (req_flag[7:4] & $past(req_flag[7:4])) == $past(req_flag[7:4]))
        else $error("shared service cleared wrong flags");

    push_pc_a: assert property (@(posedge ref_clk) disable iff (srst)
        take |=> vec_o.push && vec_o.take && vec_o.push_pc == $past(core_i.pc))
        else $error("entry did not push the pc");

    isr_exit_a: assert property (@(posedge ref_clk) disable iff (srst)
        core_i.isr_exit_instr |=> global_irq_enable && vec_o.pop)
        else $error("isr exit did not restore enable");

    plain_exit_a: assert property (@(posedge ref_clk) disable iff (srst)
        core_i.plain_exit_instr && !global_irq_enable && !sw_gie_set
        |=> !global_irq_enable && vec_o.pop)
        else $error("plain exit changed enable");

    full_stack_a: assert property (@(posedge ref_clk) disable iff (srst)
        core_i.stack_full || !global_irq_enable |-> !take)
        else $error("vector with full stack or enable low");

    take_gie_a: assert property (@(posedge ref_clk) disable iff (srst)
        take && !sw_gie_set |=> !global_irq_enable)
        else $error("enable not cleared on service");

    tick_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        take && take_idx == 3'h0 && !src_event[0] && !sw_flag_set[0] |=> !req_flag[0])
        else $error("dedicated flag not cleared");

    wake_resume_a: assert property (@(posedge ref_clk) disable iff (srst)
        s_enter_wake |=> s_restart)
        else $error("wake did not resume in time");

endmodule

// *** design/iwrc_cfg.svh ***
// constants for the interrupt wake and return control block
// How it works
// - any flag rising wakes from sleep or idle
// - enables never gate the wake path
// - external pin edges set flags while asleep
// - flags hold until serviced or cleared
// - shared service clears only the shared flag
// - entry pushes the program counter only
// - isr exit pops and sets global enable
// - plain exit pops, global enable stays low
// - vector needs all enables and free stack
// - servicing clears the global enable
// - servicing a dedicated vector clears its flag
`ifndef IWRC_CFG_SVH
`define IWRC_CFG_SVH

// ----------------------------------------------------------------
// sizes and flag positions
// ----------------------------------------------------------------
`define IWRC_NSRC 8
`define IWRC_NFLAG 9
`define IWRC_SVF_BIT 8
`define IWRC_EXT0_BIT 2
`define IWRC_EXT1_BIT 3
`define IWRC_NVEC 5
`define IWRC_SHARED_VEC 3'h4
`define IWRC_PC_W 12

// ----------------------------------------------------------------
// reset values and vector map
// ----------------------------------------------------------------
`define IWRC_GIE_RST 1'b0
`define IWRC_VEC_BASE 12'h004
`define IWRC_VEC_SHIFT 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IWRC_CLK_PERIOD_NS 5
`define IWRC_WAKE_NS 100
`define IWRC_WAKE_CYC ((`IWRC_WAKE_NS + `IWRC_CLK_PERIOD_NS - 1) / `IWRC_CLK_PERIOD_NS)

`endif

// *** design/iwrc_pkg.sv ***
// types shared by the interrupt wake and return control block
package iwrc_pkg;

    // power state of the core clocking
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_IDLE,
        PWR_WAKE
    } iwrc_pwr_e;

    // what the core reports each cycle
    typedef struct packed {
        logic boundary;
        logic [11:0] pc;
        logic isr_exit_instr;
        logic plain_exit_instr;
        logic stack_full;
        logic halt;
        logic halt_idle;
    } iwrc_core_s;

    // vectoring and stack commands back to the core
    typedef struct packed {
        logic take;
        logic [11:0] addr;
        logic push;
        logic [11:0] push_pc;
        logic pop;
    } iwrc_vec_s;

endpackage

// *** design/iwrc_flag_cell.sv ***
// one sticky interrupt request flag
`timescale 1ns/1ps
module iwrc_flag_cell (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // set and clear requests
    input wire logic set,
    input wire logic clr,
    // flag state
    output logic q,
    output logic rose
);
    logic q_d;

    // set wins so an event in the clear cycle is kept
    assign q_d = set | (q & ~clr);
    // a set on an already high flag is no transition
    assign rose = set & ~q;

    // flag storage
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= 1'b0;
        end else begin
            q <= q_d;
        end
    end
endmodule

// *** tb/iwrc_core_model.sv ***
// core stand-in: passes core status through and keeps the return stack depth
`timescale 1ns/1ps
module iwrc_core_model
    import iwrc_pkg::*;
#(
    parameter int LEVELS = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // status wanted by the bench, commands from the block
    input wire iwrc_core_s cmd,
    input wire iwrc_vec_s vec_i,
    // status seen by the block, stack depth seen by the bench
    output iwrc_core_s core_o,
    output logic [3:0] depth_q
);
    // ----
    // return stack
    // ----
    // each push adds a level and each pop drops one; only the depth is kept, no pc is stored
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            depth_q <= 4'h0;
        end else begin
            depth_q <= depth_q + {3'h0, vec_i.push} - {3'h0, vec_i.pop};
        end
    end
    // few levels: a call inside a handler would overrun them
    always_comb begin
        core_o = cmd;
        core_o.stack_full = (depth_q == 4'(LEVELS));
    end
endmodule

// *** tb/iwrc_tb.sv ***
// self-checking bench for the interrupt wake and return control block
`timescale 1ns/1ps
`include "iwrc_cfg.svh"
module iwrc_tb
    import iwrc_pkg::*;
;
    // pulse bundle bits above the event, set and clear bytes
    localparam logic [31:0] SVF_CLR = 32'h0200_0000;
    localparam logic [31:0] GIE_SET = 32'h0400_0000;
    localparam logic [31:0] GIE_CLR = 32'h0800_0000;
    localparam logic [31:0] ISR_X = 32'h1000_0000;
    localparam logic [31:0] PLN_X = 32'h2000_0000;
    localparam logic [31:0] HALT = 32'h4000_0000;
    logic ref_clk = 1'b0;
    logic srst, sve, bnd, idle;
    logic [31:0] pls;
    logic [7:0] src_enable, req_flag;
    logic [1:0] ext_pin;
    logic [11:0] pc;
    logic [3:0] depth;
    logic svf, gie, osc_run, cpu_run, periph_clk_run, wake_pulse, resume_pulse;
    iwrc_core_s cmd, core_i;
    iwrc_vec_s vec_o;
    iwrc_pwr_e pwr_state;
    int fail_count = 0;
    int comparisons = 0;
    int waited;

    always #2.5 ref_clk = ~ref_clk;
    assign cmd = '{bnd, pc, pls[28], pls[29], 1'b0, pls[30], idle};

    iwrc_core_model #(.LEVELS(1)) i_iwrc_core_model (.ref_clk(ref_clk), .srst(srst),
        .cmd(cmd), .vec_i(vec_o), .core_o(core_i), .depth_q(depth));
    iwrc_top i_iwrc_top (.ref_clk(ref_clk), .srst(srst), .src_event(pls[7:0]),
        .ext_pin(ext_pin), .sw_flag_set(pls[15:8]), .sw_flag_clr(pls[23:16]),
        .src_enable(src_enable), .shared_vector_enable(sve), .sw_svf_set(pls[24]),
        .sw_svf_clr(pls[25]), .sw_gie_set(pls[26]), .sw_gie_clr(pls[27]),
        .core_i(core_i), .vec_o(vec_o), .req_flag(req_flag), .shared_vector_flag(svf),
        .global_irq_enable(gie), .pwr_state(pwr_state), .osc_run(osc_run),
        .cpu_run(cpu_run), .periph_clk_run(periph_clk_run), .wake_pulse(wake_pulse),
        .resume_pulse(resume_pulse));

    // ----
    // access tasks
    // ----
    task automatic print_verdict;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_pwr(input iwrc_pwr_e got, input iwrc_pwr_e exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: power state %0d", $time, got);
        end
    endtask

    // one cycle of pulses; a gap cycle follows so no signal is driven twice
    task automatic pulse(input logic [31:0] p);
        @(posedge ref_clk);
        pls <= p;
        @(posedge ref_clk);
        pls <= '0;
    endtask

    // sel 0 take, 2 wake, else resume; must=0 means none may come
    task automatic wait_on(input int sel, input int lim, input bit must);
        logic hit;
        int n;
        hit = 1'b0;
        n = 0;
        while (hit !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
            hit = (sel == 0) ? vec_o.take : (sel == 2) ? wake_pulse : resume_pulse;
        end
        waited = n;
        if (!must) begin
            chk({11'h0, hit}, 12'h0, "event while blocked");
        end else if (hit !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: wait ran out", $time);
            print_verdict();
        end
    endtask

    // ----
    // test sequence
    // ----
    initial begin
        srst = 1'b1;
        pls = '0;
        src_enable = '0;
        sve = 1'b0;
        ext_pin = '0;
        bnd = 1'b0;
        idle = 1'b0;
        pc = '0;
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        bnd <= 1'b1;
        src_enable <= 8'hff;
        sve <= 1'b1;
        pulse(32'h0000_001f);
        wait_on(0, 8, 0);
        chk({3'h0, req_flag, svf}, 12'h03f, "pending flags");
        // lowest index first, each exit re-arms the next
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            pc <= 12'h100 + 12'(i);
            pulse(i == 0 ? GIE_SET : ISR_X);
            @(negedge ref_clk);
            if (i > 0) chk({10'h0, vec_o.pop, gie}, 12'h003, "isr exit");
            wait_on(0, 8, 1);
            chk(vec_o.addr, `IWRC_VEC_BASE + 12'(i << `IWRC_VEC_SHIFT), "vector");
            chk(vec_o.push_pc, 12'h100 + 12'(i), "pushed pc");
            chk({10'h0, vec_o.push, gie}, 12'h002, "entry");
            chk({3'h0, req_flag, svf}, {3'h0, 8'h10 | (8'h1f & ~((8'h2 << i) - 8'h1)),
                i < 4}, "auto clear");
        end
        pulse(ISR_X | 32'h0010_0000);
        // flags update on the edge that ends the pulse, look after it settles
        @(negedge ref_clk);
        chk({4'h0, req_flag}, 12'h000, "member clear");
        pulse(32'h0000_0002);
        wait_on(0, 8, 1);
        pulse(PLN_X | 32'h0000_0001);
        @(negedge ref_clk);
        chk({10'h0, vec_o.pop, gie}, 12'h002, "plain exit");
        wait_on(0, 8, 0);
        @(posedge ref_clk);
        src_enable <= 8'hfe;
        pulse(GIE_SET);
        wait_on(0, 8, 0);
        chk({11'h0, req_flag[0]}, 12'h001, "held flag");
        @(posedge ref_clk);
        src_enable <= 8'hff;
        wait_on(0, 8, 1);
        // the push lands in the stack one edge after take
        @(negedge ref_clk);
        chk({8'h0, depth}, 12'h001, "stack depth");
        pulse(GIE_SET | 32'h0000_0002);
        wait_on(0, 8, 0);
        // quiet everything before the low-power checks
        pulse(GIE_CLR | PLN_X | SVF_CLR | 32'h00ff_0000);
        @(posedge ref_clk);
        src_enable <= 8'h00;
        sve <= 1'b0;
        pulse(HALT);
        @(negedge ref_clk);
        chk_pwr(pwr_state, PWR_SLEEP);
        chk({9'h0, osc_run, periph_clk_run, cpu_run}, 12'h000, "clocks stopped");
        @(posedge ref_clk);
        ext_pin <= 2'b01;
        wait_on(2, 8, 1);
        chk({11'h0, req_flag[2]}, 12'h001, "pin flag");
        chk_pwr(pwr_state, PWR_WAKE);
        chk({9'h0, osc_run, periph_clk_run, cpu_run}, 12'h006, "waking clocks");
        wait_on(3, 40, 1);
        chk(12'(waited), 12'(`IWRC_WAKE_CYC), "wake time");
        chk({11'h0, cpu_run}, 12'h001, "cpu running");
        // preset flag mutes the pin, another source still wakes
        pulse(32'h0000_0800);
        @(posedge ref_clk);
        idle <= 1'b1;
        pulse(HALT);
        @(negedge ref_clk);
        chk_pwr(pwr_state, PWR_IDLE);
        chk({9'h0, osc_run, periph_clk_run, cpu_run}, 12'h002, "idle clocks");
        @(posedge ref_clk);
        ext_pin <= 2'b11;
        wait_on(2, 8, 0);
        pulse(32'h0000_0020);
        wait_on(2, 8, 1);
        wait_on(3, 40, 1);
        chk_pwr(pwr_state, PWR_RUN);
        print_verdict();
    end
endmodule
